/* File: core/sfc_cache_policy.sv */
// Resolves the true write cache state from policy and Set Features.
`timescale 1ns/1ps
module sfc_cache_policy (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] policy,
  input wire logic setf_wce,
  output logic cache_on
);

  logic next_cache_on;

  // A forced policy overrides whatever Set Features last asked for.
  always_comb begin
    unique case (policy)
      sfc_pkg::WC_FORCE_ON: next_cache_on = 1'b1;
      sfc_pkg::WC_FORCE_OFF: next_cache_on = 1'b0;
      default: next_cache_on = setf_wce;
    endcase
  end

  // Registered so the cache enable seen downstream is glitch free.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cache_on <= sfc_pkg::SETF_WCE_RESET;
    end else begin
      cache_on <= next_cache_on;
    end
  end

endmodule

/* File: core/sfc_feature_ctrl.sv */
// Feature control command interpreter for write cache and reordering.
// Function
// - Good completion returns error 00h and status 50h.
// - Get state returns state low byte then high byte.
// - Get flags returns flags low then high; otherwise reserved.
// - Write cache feature accepts follow, force on, force off.
// - Forced policy holds cache on or off regardless of Set Features.
// - Set Features under forced policy completes cleanly, cache unchanged.
// - Identify word 85 bit 5 shows true cache state.
// - With no stored setting, reset selects follow Set Features.
// - Reordering: 0001h enable, 0002h disable, default enable.
// - Disable reordering completes cleanly but reordering stays on.
// - Function code selects set, get state or get flags.
// - Option bit 0 makes a set persistent; otherwise volatile.
`timescale 1ns/1ps
module sfc_feature_ctrl (
  input wire logic CLK,
  input wire logic NRST,
  // Command request, one cycle while CMD_READY is high.
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [15:0] CMD_FUNC,
  input wire logic [15:0] CMD_FEATURE,
  input wire logic [15:0] CMD_STATE,
  input wire logic [15:0] CMD_OPTIONS,
  // Completion and returned task-file bytes.
  output logic CMD_DONE,
  output logic [7:0] ERROR_REPORT,
  output logic [7:0] RETURN_LOW_BYTE,
  output logic [7:0] RETURN_HIGH_BYTE,
  output logic [7:0] SPARE_LOW_FIELD,
  output logic [7:0] SPARE_HIGH_FIELD,
  output logic [7:0] TARGET_SELECT,
  output logic [7:0] COMPLETION_STATE,
  // Set Features write cache request.
  input wire logic SETF_VALID,
  input wire logic SETF_WCE,
  output logic SETF_DONE,
  // Stored settings offered at reset release.
  input wire logic NV_VALID,
  input wire logic [15:0] NV_WC_POLICY,
  // Persistent store write strobe.
  output logic NV_WR,
  output logic [15:0] NV_WR_FEATURE,
  output logic [15:0] NV_WR_STATE,
  // Effective feature state.
  output logic WCACHE_ON,
  output logic IDENT_WCACHE,
  output logic REORDER_ON
);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  typedef enum logic [3:0] {
    SFC_LOAD = 4'b0001,
    SFC_IDLE = 4'b0010,
    SFC_EXEC = 4'b0100,
    SFC_RESP = 4'b1000
  } sfc_state_t;

  sfc_state_t state;
  sfc_state_t next_state;

  logic [15:0] func_q;
  logic [15:0] feature_q;
  logic [15:0] state_q;
  logic persist_q;
  logic [15:0] wc_policy;
  logic setf_wce;
  logic wc_persist;
  logic ro_persist;
  logic cache_on;
  logic func_ok;
  logic feature_ok;
  logic state_ok;
  logic cmd_ok;
  logic [15:0] ro_state;
  logic [15:0] ret_word;
  logic forced;

  // The stored settings are taken in the first cycle after reset
  // release rather than under reset, so no port feeds a reset value.
  always_comb begin
    unique case (state)
      SFC_LOAD: next_state = SFC_IDLE;
      SFC_IDLE: next_state = CMD_VALID ? SFC_EXEC : SFC_IDLE;
      SFC_EXEC: next_state = SFC_RESP;
      SFC_RESP: next_state = SFC_IDLE;
      default: next_state = SFC_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state <= SFC_LOAD;
    end else begin
      state <= next_state;
    end
  end

  // One command in flight; the host must wait for ready again.
  assign CMD_READY = (state == SFC_IDLE);

  // ****************************************************************
  // Request capture
  // ****************************************************************
  // Latch the request words so the host may change them afterwards.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      func_q <= 16'h0000;
      feature_q <= 16'h0000;
      state_q <= 16'h0000;
      persist_q <= 1'b0;
    end else if (CMD_VALID && CMD_READY) begin
      func_q <= CMD_FUNC;
      feature_q <= CMD_FEATURE;
      state_q <= CMD_STATE;
      persist_q <= CMD_OPTIONS[sfc_pkg::OPT_PERSIST_BIT];
    end
  end

  // ****************************************************************
  // Decode and validation
  // ****************************************************************
  // Function code picks the operation.
  always_comb begin
    func_ok = (func_q == sfc_pkg::FUNC_SET) ||
              (func_q == sfc_pkg::FUNC_GET_STATE) ||
              (func_q == sfc_pkg::FUNC_GET_FLAGS);
  end

  // Only the two known features are served.
  always_comb begin
    feature_ok = (feature_q == sfc_pkg::FEAT_WCACHE) ||
                 (feature_q == sfc_pkg::FEAT_REORDER);
  end

  // State words are only checked on a set; gets ignore the field.
  always_comb begin
    state_ok = 1'b1;
    if (func_q == sfc_pkg::FUNC_SET) begin
      if (feature_q == sfc_pkg::FEAT_WCACHE) begin
        state_ok = (state_q == sfc_pkg::WC_FOLLOW_SETF) ||
                   (state_q == sfc_pkg::WC_FORCE_ON) ||
                   (state_q == sfc_pkg::WC_FORCE_OFF);
      end else begin
        state_ok = (state_q == sfc_pkg::RO_ENABLE) ||
                   (state_q == sfc_pkg::RO_DISABLE);
      end
    end
  end

  // Any bad field aborts the whole request.
  assign cmd_ok = func_ok && feature_ok && state_ok;

  // ****************************************************************
  // Write cache policy
  // ****************************************************************
  // Policy register: stored setting at start-up, else follow mode.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wc_policy <= sfc_pkg::WC_POLICY_RESET;
    end else if (state == SFC_LOAD) begin
      if (NV_VALID) begin
        wc_policy <= NV_WC_POLICY;
      end
    end else if (state == SFC_EXEC && cmd_ok &&
                 func_q == sfc_pkg::FUNC_SET &&
                 feature_q == sfc_pkg::FEAT_WCACHE) begin
      wc_policy <= state_q;
    end
  end

  assign forced = (wc_policy != sfc_pkg::WC_FOLLOW_SETF);

  // Set Features is only recorded in follow mode; while forced it is
  // dropped, so a later return to follow keeps the pre-force setting.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      setf_wce <= sfc_pkg::SETF_WCE_RESET;
    end else if (SETF_VALID && !forced) begin
      setf_wce <= SETF_WCE;
    end
  end

  // Set Features always completes without error, forced or not.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      SETF_DONE <= 1'b0;
    end else begin
      SETF_DONE <= SETF_VALID;
    end
  end

  // Effective cache state from policy and Set Features.
  sfc_cache_policy u_policy (
    .clk(CLK),
    .nrst(NRST),
    .policy(wc_policy),
    .setf_wce(setf_wce),
    .cache_on(cache_on)
  );

  assign WCACHE_ON = cache_on;
  // Identify word 85 bit 5 mirrors the true state in every policy.
  assign IDENT_WCACHE = cache_on;

  // ****************************************************************
  // Persistence flags
  // ****************************************************************
  // Remember whether each feature's last set was persistent; these
  // are what a flags query reports back.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wc_persist <= sfc_pkg::PERSIST_RESET;
      ro_persist <= sfc_pkg::PERSIST_RESET;
    end else if (state == SFC_LOAD) begin
      wc_persist <= NV_VALID;
    end else if (state == SFC_EXEC && cmd_ok &&
                 func_q == sfc_pkg::FUNC_SET) begin
      if (feature_q == sfc_pkg::FEAT_WCACHE) begin
        wc_persist <= persist_q;
      end else begin
        ro_persist <= persist_q;
      end
    end
  end

  // A persistent set of the cache policy goes to the store; the
  // reordering state is never stored since it cannot change.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      NV_WR <= 1'b0;
      NV_WR_FEATURE <= 16'h0000;
      NV_WR_STATE <= 16'h0000;
    end else begin
      NV_WR <= (state == SFC_EXEC) && cmd_ok && persist_q &&
               (func_q == sfc_pkg::FUNC_SET) &&
               (feature_q == sfc_pkg::FEAT_WCACHE);
      if (state == SFC_EXEC) begin
        NV_WR_FEATURE <= feature_q;
        NV_WR_STATE <= state_q;
      end
    end
  end

  // ****************************************************************
  // Reordering
  // ****************************************************************
  // Disable is accepted but has no effect, so reordering stays on.
  assign ro_state = sfc_pkg::RO_ENABLE;
  assign REORDER_ON = 1'b1;

  // ****************************************************************
  // Completion
  // ****************************************************************
  // Word returned by a get, chosen by function and feature.
  always_comb begin
    ret_word = 16'h0000;
    if (func_q == sfc_pkg::FUNC_GET_STATE) begin
      ret_word = (feature_q == sfc_pkg::FEAT_WCACHE) ?
                 wc_policy : ro_state;
    end else if (func_q == sfc_pkg::FUNC_GET_FLAGS) begin
      ret_word = {15'h0000, (feature_q == sfc_pkg::FEAT_WCACHE) ?
                 wc_persist : ro_persist};
    end
  end

  // Completion pulse and task-file bytes, held until the next command.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      CMD_DONE <= 1'b0;
      ERROR_REPORT <= sfc_pkg::ERR_NONE;
      RETURN_LOW_BYTE <= sfc_pkg::RSVD_BYTE;
      RETURN_HIGH_BYTE <= sfc_pkg::RSVD_BYTE;
      COMPLETION_STATE <= sfc_pkg::STAT_GOOD;
    end else begin
      CMD_DONE <= (state == SFC_EXEC);
      if (state == SFC_EXEC) begin
        if (cmd_ok) begin
          ERROR_REPORT <= sfc_pkg::ERR_NONE;
          COMPLETION_STATE <= sfc_pkg::STAT_GOOD;
          RETURN_LOW_BYTE <= ret_word[7:0];
          RETURN_HIGH_BYTE <= ret_word[15:8];
        end else begin
          ERROR_REPORT <= sfc_pkg::ERR_ABORT;
          COMPLETION_STATE <= sfc_pkg::STAT_FAIL;
          RETURN_LOW_BYTE <= sfc_pkg::RSVD_BYTE;
          RETURN_HIGH_BYTE <= sfc_pkg::RSVD_BYTE;
        end
      end
    end
  end

  // Reserved bytes read as zero in every answer.
  assign SPARE_LOW_FIELD = sfc_pkg::RSVD_BYTE;
  assign SPARE_HIGH_FIELD = sfc_pkg::RSVD_BYTE;
  assign TARGET_SELECT = sfc_pkg::RSVD_BYTE;

endmodule

/* File: shared/sfc_pkg.sv */
// Constants shared by the feature control command interpreter.
package sfc_pkg;

  // ****************************************************************
  // Command words
  // ****************************************************************
  localparam logic [15:0] FUNC_SET = 16'h0001;
  localparam logic [15:0] FUNC_GET_STATE = 16'h0002;
  localparam logic [15:0] FUNC_GET_FLAGS = 16'h0003;
  localparam logic [15:0] FEAT_WCACHE = 16'h0001;
  localparam logic [15:0] FEAT_REORDER = 16'h0002;

  // Write cache policy states.
  localparam logic [15:0] WC_FOLLOW_SETF = 16'h0001;
  localparam logic [15:0] WC_FORCE_ON = 16'h0002;
  localparam logic [15:0] WC_FORCE_OFF = 16'h0003;

  // Reordering states.
  localparam logic [15:0] RO_ENABLE = 16'h0001;
  localparam logic [15:0] RO_DISABLE = 16'h0002;

  // Option flag field: bit 0 asks for a persistent change.
  localparam int OPT_PERSIST_BIT = 0;

  // ****************************************************************
  // Returned task-file values
  // ****************************************************************
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] STAT_GOOD = 8'h50;
  localparam logic [7:0] STAT_FAIL = 8'h51;
  localparam logic [7:0] RSVD_BYTE = 8'h00;

  // ****************************************************************
  // Reset values and identify reflection
  // ****************************************************************
  localparam logic [15:0] WC_POLICY_RESET = WC_FOLLOW_SETF;
  localparam logic SETF_WCE_RESET = 1'b1;
  localparam logic PERSIST_RESET = 1'b0;
  localparam int IDENT_WORD = 85;
  localparam int IDENT_WCACHE_BIT = 5;

endpackage

/* File: sim/sfc_host_model.sv */
// Host controller model issuing feature control and Set Features requests.
`timescale 1ns/1ps
module sfc_host_model (
  input wire logic clk,
  input wire logic ready,
  input wire logic done,
  output logic valid,
  output logic [15:0] func,
  output logic [15:0] feat,
  output logic [15:0] state,
  output logic [15:0] opts,
  output logic setf_valid,
  output logic setf_wce
);
  // Idle at time zero.
  initial begin
    valid = 1'b0;
    {func, feat, state, opts} = 64'h0;
    setf_valid = 1'b0;
    setf_wce = 1'b0;
  end
  // One request, driven for one cycle once ready is seen; stale words are inverted afterwards.
  task automatic send(input logic [15:0] f, ft, s, o, output logic ok);
    int n;
    n = 0;
    repeat ($urandom_range(3)) @(negedge clk);
    while (!ready && n < 50) begin
      @(negedge clk);
      n++;
    end
    valid = 1'b1;
    func = f;
    feat = ft;
    state = s;
    opts = o;
    @(negedge clk);
    valid = 1'b0;
    {func, feat, state, opts} = ~{f, ft, s, o};
    while (!done && n < 50) begin
      @(negedge clk);
      n++;
    end
    ok = done;
  endtask
  // One Set Features cache request.
  task automatic setf(input logic w);
    setf_valid = 1'b1;
    setf_wce = w;
    @(negedge clk);
    setf_valid = 1'b0;
    setf_wce = ~w;
  endtask
endmodule

/* File: sim/sfc_props.sv */
// Port checker for the feature control interpreter.
`timescale 1ns/1ps
module sfc_props (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CMD_VALID,
  input wire logic CMD_READY,
  input wire logic [15:0] CMD_FUNC,
  input wire logic [15:0] CMD_FEATURE,
  input wire logic [15:0] CMD_STATE,
  input wire logic CMD_DONE,
  input wire logic [7:0] ERROR_REPORT,
  input wire logic [7:0] RETURN_LOW_BYTE,
  input wire logic [7:0] RETURN_HIGH_BYTE,
  input wire logic [7:0] COMPLETION_STATE,
  input wire logic SETF_VALID,
  input wire logic SETF_WCE,
  input wire logic SETF_DONE,
  input wire logic WCACHE_ON,
  input wire logic IDENT_WCACHE,
  input wire logic REORDER_ON,
  input wire logic NV_VALID,
  input wire logic [15:0] NV_WC_POLICY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic tk, good, busy, bad, setw, first;
  logic [1:0] kind;
  logic [15:0] held, pol, ret;
  // Classify each taken request; the policy copy commits only at completion.
  assign tk = CMD_VALID && CMD_READY;
  assign ret = {RETURN_HIGH_BYTE, RETURN_LOW_BYTE};
  assign good = CMD_FUNC == 16'h1 ?
    (CMD_FEATURE == 16'h1 && CMD_STATE inside {[16'h1:16'h3]}) ||
    (CMD_FEATURE == 16'h2 && CMD_STATE inside {[16'h1:16'h2]}) :
    CMD_FUNC inside {[16'h2:16'h3]} && CMD_FEATURE inside {[16'h1:16'h2]};
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      busy <= 1'b0;
      bad <= 1'b0;
      setw <= 1'b0;
      kind <= 2'h0;
      held <= 16'h0;
      pol <= 16'h1;
      first <= 1'b1;
    end else if (first) begin
      // A stored policy is taken in the first cycle after release.
      first <= 1'b0;
      if (NV_VALID) begin
        pol <= NV_WC_POLICY;
      end
    end else if (tk) begin
      busy <= 1'b1;
      bad <= !good;
      setw <= CMD_FUNC == 16'h1 && CMD_FEATURE == 16'h1;
      kind <= {CMD_FUNC == 16'h2, CMD_FEATURE == 16'h1};
      held <= CMD_STATE;
    end else if (CMD_DONE) begin
      busy <= 1'b0;
      if (setw && !bad) begin
        pol <= held;
      end
    end
  end
  property p_ok; CMD_DONE && !bad |-> ERROR_REPORT == 8'h00 &&
    COMPLETION_STATE == 8'h50; endproperty
  a_ok: assert property (p_ok) else $error("bad good-completion code");
  property p_lat; tk |-> ##[1:3] CMD_DONE; endproperty
  a_lat: assert property (p_lat) else $error("no completion");
  property p_abort; CMD_DONE && bad |-> ERROR_REPORT == 8'h04 &&
    COMPLETION_STATE == 8'h51 && ret == 16'h0; endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_get; CMD_DONE && !bad && kind == 2'h3 |-> ret == pol;
  endproperty
  a_get: assert property (p_get) else $error("wrong policy word");
  property p_getro; CMD_DONE && !bad && kind == 2'h2 |-> ret == 16'h1 &&
    REORDER_ON; endproperty
  a_getro: assert property (p_getro) else $error("reorder");
  property p_hold; (pol != 16'h1 && $stable(pol))[*3] |->
    WCACHE_ON == (pol == 16'h2); endproperty
  a_hold: assert property (p_hold) else $error("forced cache lost");
  property p_setf; SETF_VALID |=> SETF_DONE; endproperty
  a_setf: assert property (p_setf) else $error("no set done");
  property p_id; IDENT_WCACHE == WCACHE_ON; endproperty
  a_id: assert property (p_id) else $error("identify bit wrong");
  property p_follow; SETF_VALID && pol == 16'h1 && !busy && !tk ##1
    (!SETF_VALID && !tk)[*3] |-> WCACHE_ON == $past(SETF_WCE, 3);
  endproperty
  a_follow: assert property (p_follow) else $error("follow lost");
  c_abort: cover property (CMD_DONE && bad);
  c_force: cover property (pol == 16'h3 && SETF_VALID && SETF_WCE);
  c_get: cover property (CMD_DONE && !bad && kind == 2'h3);
  c_load: cover property (first && NV_VALID);
endmodule
bind sfc_feature_ctrl sfc_props props_u (.CLK, .NRST, .CMD_VALID,
  .CMD_READY, .CMD_FUNC, .CMD_FEATURE, .CMD_STATE, .CMD_DONE,
  .ERROR_REPORT, .RETURN_LOW_BYTE, .RETURN_HIGH_BYTE, .COMPLETION_STATE,
  .SETF_VALID, .SETF_WCE, .SETF_DONE, .WCACHE_ON, .IDENT_WCACHE,
  .REORDER_ON, .NV_VALID, .NV_WC_POLICY);

/* File: sim/tb.sv */
// Self-checking bench for the feature control interpreter.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic valid, ready, done, sv, sw_in, nv_wr, wc_on, id_wc, ro_on, ok;
  logic [15:0] func, feat, state, opts, pol;
  logic [7:0] err, lo, hi, stat;
  logic pw, pr, sw;
  logic [7:0] sl, sh, ts;
  logic nv_ok = 1'b0;
  logic [15:0] nv_st, nv_feat;
  logic [15:0] nv_pol = 16'h0001;
  logic [15:0] nv_p = 16'h0001;
  int bad_count = 0;
  int checks_done = 0;
  int nv_seen = 0;
  int nv_exp = 0;
  always #2.5 clk = ~clk;
  // Persistent store at the far side; it keeps the last stored policy.
  always @(negedge clk) begin
    if (nv_wr) begin
      nv_seen++;
      nv_ok <= 1'b1;
      nv_pol <= nv_st;
      chk(nv_feat, 16'h1, "store feature");
    end
  end
  sfc_host_model host_u (.clk(clk), .ready(ready), .done(done),
    .valid(valid), .func(func), .feat(feat), .state(state), .opts(opts),
    .setf_valid(sv), .setf_wce(sw_in));
  sfc_feature_ctrl dut_u (.CLK(clk), .NRST(nrst), .CMD_VALID(valid),
    .CMD_READY(ready), .CMD_FUNC(func), .CMD_FEATURE(feat),
    .CMD_STATE(state), .CMD_OPTIONS(opts), .CMD_DONE(done),
    .ERROR_REPORT(err), .RETURN_LOW_BYTE(lo), .RETURN_HIGH_BYTE(hi),
    .SPARE_LOW_FIELD(sl), .SPARE_HIGH_FIELD(sh), .TARGET_SELECT(ts),
    .COMPLETION_STATE(stat), .SETF_VALID(sv), .SETF_WCE(sw_in),
    .SETF_DONE(), .NV_VALID(nv_ok), .NV_WC_POLICY(nv_pol), .NV_WR(nv_wr),
    .NV_WR_FEATURE(nv_feat), .NV_WR_STATE(nv_st), .WCACHE_ON(wc_on),
    .IDENT_WCACHE(id_wc), .REORDER_ON(ro_on));
  // Shared comparison.
  task automatic chk(input logic [15:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Cache state the bench expects from policy and Set Features.
  function automatic logic wc_exp();
    return pol == 16'h2 ? 1'b1 : pol == 16'h3 ? 1'b0 : sw;
  endfunction
  // Reset, then the defaults or the last persistent cache policy.
  task automatic do_reset();
    nrst = 1'b0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    pol = nv_exp > 0 ? nv_p : 16'h1;
    pw = nv_exp > 0;
    {pr, sw} = 2'b01;
    repeat (2) @(negedge clk);
    chk({13'h0, wc_on, id_wc, ro_on},
      {13'h0, wc_exp(), wc_exp(), 1'b1}, "reset");
  endtask
  // Set Features request; a forced policy ignores it.
  task automatic setf(input logic w);
    host_u.setf(w);
    if (pol == 16'h1)
      sw = w;
    repeat (3) @(negedge clk);
    chk({15'h0, wc_on}, {15'h0, wc_exp()}, "cache");
  endtask
  // One command with the expected completion worked out here.
  task automatic cmd(input logic [15:0] f, ft, s, o);
    logic g;
    logic [15:0] r;
    g = f == 16'h1 ? (ft == 16'h1 && s inside {[16'h1:16'h3]}) ||
      (ft == 16'h2 && s inside {[16'h1:16'h2]}) :
      f inside {[16'h2:16'h3]} && ft inside {[16'h1:16'h2]};
    r = f == 16'h2 ? (ft == 16'h1 ? pol : 16'h1) :
      f == 16'h3 ? {15'h0, ft == 16'h1 ? pw : pr} : 16'h0;
    host_u.send(f, ft, s, o, ok);
    chk({15'h0, ok}, 16'h1, "done");
    chk({err, stat}, g ? 16'h0050 : 16'h0451, "status");
    chk({hi, lo}, g ? r : 16'h0, "word");
    chk({sl, sh}, 16'h0, "spare");
    chk({8'h0, ts}, 16'h0, "select");
    if (g && f == 16'h1 && ft == 16'h1) begin
      pol = s;
      pw = o[0];
      nv_exp += int'(o[0]);
      if (o[0])
        nv_p = s;
    end
    if (g && f == 16'h1 && ft == 16'h2)
      pr = o[0];
  endtask
  // Main sequence: defaults, every policy, reordering, faults, random.
  initial begin
    void'($urandom(87615));
    do_reset();
    cmd(16'h2, 16'h1, 16'h0, 16'h0);
    for (int i = 1; i <= 3; i++) begin
      cmd(16'h1, 16'h1, 16'(i), {15'h0, 1'($urandom)});
      cmd(16'h2, 16'h1, 16'h0, 16'h0);
      cmd(16'h3, 16'h1, 16'h0, 16'h0);
      setf(1'b0);
      setf(1'b1);
    end
    $display("policy test done");
    cmd(16'h1, 16'h2, 16'h2, 16'h1);
    cmd(16'h2, 16'h2, 16'h0, 16'h0);
    cmd(16'h3, 16'h2, 16'h0, 16'h0);
    cmd(16'h1, 16'h1, 16'h4, 16'h0);
    cmd(16'h1, 16'h3, 16'h1, 16'h0);
    cmd(16'h4, 16'h1, 16'h1, 16'h0);
    $display("reorder and fault test done");
    for (int i = 0; i < 60; i++) begin
      if ($urandom_range(2) == 0)
        setf(1'($urandom));
      else
        cmd(16'($urandom_range(1, 3)), 16'($urandom_range(0, 3)),
          16'($urandom_range(0, 4)), {15'h0, 1'($urandom)});
    end
    $display("random test done");
    cmd(16'h1, 16'h1, 16'h3, 16'h1);
    cmd(16'h1, 16'h1, 16'h1, 16'h0);
    chk(16'(nv_seen), 16'(nv_exp), "store writes");
    do_reset();
    cmd(16'h2, 16'h1, 16'h0, 16'h0);
    cmd(16'h3, 16'h1, 16'h0, 16'h0);
    $display("reset test done");
    print_verdict();
  end
  // Cuts a hang short.
  initial begin
    #100us;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
  // Counts and verdict.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
endmodule
